// [crx_can_node.sv]
// behavioural remote node handing received identifiers to the block
`timescale 1ns/1ps
module crx_can_node (
  input  wire logic        sys_clk,   // module clock
  output logic             msg_valid, // identifier ready, one cycle
  output logic      [10:0] msg_sid,   // standard identifier
  output logic      [17:0] msg_eid,   // extended identifier
  output logic             msg_ide    // frame carries extended id
);
  // ---------------------------------------------------------------
  // idle lines
  // ---------------------------------------------------------------
  initial begin
    msg_valid = 1'b0;
    msg_sid   = 11'h000;
    msg_eid   = 18'h0_0000;
    msg_ide   = 1'b0;
  end

  // one frame: valid for a single cycle, then the id lines invert so a
  // stale identifier can never pass for a fresh one
  task automatic send(input logic [10:0] s, input logic [17:0] e,
                      input logic x);
    @(posedge sys_clk);
    msg_valid <= 1'b1;
    msg_sid   <= s;
    msg_eid   <= e;
    msg_ide   <= x;
    @(posedge sys_clk);
    msg_valid <= 1'b0;
    msg_sid   <= ~s;
    msg_eid   <= ~e;
    msg_ide   <= ~x;
  endtask
endmodule

// [crx_flag_bank.sv]
`timescale 1ns/1ps
// bank of hardware-set, software-cleared sticky flags
`include "crx_regs.svh"
module crx_flag_bank
  import crx_pkg::*;
#(
  parameter int NUM = 32
) (
  input  wire logic           sys_clk, // module clock
  input  wire logic           rst,     // sync reset, active high
  input  wire logic [NUM-1:0] set_vec, // hardware set, one per flag
  input  wire logic [NUM-1:0] clr_vec, // software clear, one per flag
  output logic      [NUM-1:0] flags    // flag state
);

  logic [NUM-1:0] flags_ff;

  // set beats a clear landing in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags_ff <= NUM'(`CRX_FLAG_RST);
    end else begin
      flags_ff <= (flags_ff & ~clr_vec) | set_vec;
    end
  end

  assign flags = flags_ff;

  a_set_wins_clr: assert property (@(posedge sys_clk) disable iff (rst)
    set_vec != '0 |=> (flags & $past(set_vec)) == $past(set_vec))
    else $error("flag set was lost");

  a_sw_no_set: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> (flags & ~$past(flags) & ~$past(set_vec)) == '0)
    else $error("flag rose without a hardware set");

  a_clear_takes: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> (flags & $past(clr_vec) & ~$past(set_vec)) == '0)
    else $error("software clear did not take");

endmodule

// [crx_mask_if.sv]
`timescale 1ns/1ps
// carries the mask chosen for one filter to its comparator
interface crx_mask_if;
  import crx_pkg::*;
  logic         valid;  // selector names a defined mask
  crx_mask_type mask;   // the selected mask fields

  modport src (output valid, output mask);
  modport dst (input valid, input mask);
endinterface

// [crx_mask_match.sv]
`timescale 1ns/1ps
// identifier comparison of one acceptance filter under its selected mask
module crx_mask_match
  import crx_pkg::*;
(
  crx_mask_if.dst           mif,                    // selected mask
  input  wire logic [10:0]  msg_sid,                // message standard id
  input  wire logic [17:0]  msg_eid,                // message extended id
  input  wire logic         msg_ide,                // message is extended
  input  wire logic         filt_en,                // filter enabled
  input  wire logic [10:0]  filt_sid,               // filter standard id
  input  wire logic [17:0]  filt_eid,               // filter extended id
  input  wire logic         filter_extended_enable, // filter type choice
  output logic              hit                     // filter accepts
);

  logic sid_ok;
  logic eid_ok;
  logic type_ok;

  // only bits whose mask bit is one take part
  assign sid_ok = ((msg_sid ^ filt_sid) & mif.mask.sid) == 11'h000;
  assign eid_ok = ((msg_eid ^ filt_eid) & mif.mask.eid) == 18'h0_0000;

  // type only matters while the mask enforces it
  assign type_ok = !mif.mask.mask_type_enforce
                   || (msg_ide == filter_extended_enable);

  // standard frames have no extended bits to compare
  assign hit = filt_en && mif.valid && type_ok && sid_ok
               && (!msg_ide || eid_ok);

endmodule

// [crx_pkg.sv]
// types shared by the rx acceptance block
package crx_pkg;

  // mask source selector codes
  typedef enum logic [1:0] {
    CRX_MSK0     = 2'b00,
    CRX_MSK1     = 2'b01,
    CRX_MSK2     = 2'b10,
    CRX_MSK_RSVD = 2'b11
  } crx_msel_type;

  // one acceptance mask, unpacked from its two registers
  typedef struct packed {
    logic [10:0] sid;
    logic [17:0] eid;
    logic        mask_type_enforce;
  } crx_mask_type;

endpackage

// [crx_regs.svh]
// register map, field positions and reset values of the rx acceptance block
`ifndef CRX_REGS_SVH
`define CRX_REGS_SVH

// word offsets on the register port
`define CRX_OFS_MSEL     5'h00
`define CRX_OFS_M0_SID   5'h01
`define CRX_OFS_M0_EID   5'h02
`define CRX_OFS_M1_SID   5'h03
`define CRX_OFS_M1_EID   5'h04
`define CRX_OFS_M2_SID   5'h05
`define CRX_OFS_M2_EID   5'h06
`define CRX_OFS_FUL_LO   5'h07
`define CRX_OFS_FUL_HI   5'h08
`define CRX_OFS_OVF_LO   5'h09
`define CRX_OFS_OVF_HI   5'h0A
`define CRX_OFS_IRQ_STAT 5'h0B
`define CRX_OFS_IRQ_MASK 5'h0C

// field positions in the SID mask register
`define CRX_SID_MSB  15
`define CRX_SID_LSB  5
`define CRX_MASK_TYPE_ENFORCE_BIT 3
`define CRX_EIDH_MSB 1
`define CRX_SID_WMASK 16'hFFEB

// reset values and codes
`define CRX_MSEL_RST  16'h0000
`define CRX_FLAG_RST  32'h0000_0000
`define CRX_MASK_RST  16'h0000
`define CRX_PTR_FIFO  4'hF
`define CRX_FILT_BASE 5'h08

// interrupt status bits
`define CRX_IRQ_STORE  0
`define CRX_IRQ_OVF    1
`define CRX_IRQ_REJECT 2

`endif

// [crx_rx_accept.sv]
`timescale 1ns/1ps
// rx acceptance masks for filters 8-15 and receive buffer status flags
`include "crx_regs.svh"
module crx_rx_accept
  import crx_pkg::*;
#(
  parameter int NFILT = 8,
  parameter int NBUF  = 32
) (
  input  wire logic               sys_clk,      // module clock, 10 MHz
  input  wire logic               rst,          // sync reset, active high
  input  wire logic [4:0]         reg_addr,     // register word offset
  input  wire logic [15:0]        reg_wdata,    // register write data
  input  wire logic               reg_wr,       // write strobe
  input  wire logic               reg_rd,       // read strobe
  output logic      [15:0]        reg_rdata,    // read data, cycle after rd
  output logic                    irq,          // level interrupt
  input  wire logic               msg_valid,    // received id ready, pulse
  input  wire logic [10:0]        msg_sid,      // message standard id
  input  wire logic [17:0]        msg_eid,      // message extended id
  input  wire logic               msg_ide,      // message is extended
  input  wire logic [NFILT-1:0]   filt_en,      // filter enables
  input  wire logic [NFILT*11-1:0] filt_sid,    // filter standard ids
  input  wire logic [NFILT*18-1:0] filt_eid,    // filter extended ids
  input  wire logic [NFILT-1:0]   filter_extended_enable, // type choice
  input  wire logic [NFILT*4-1:0] filter_buffer_pointer,  // target buffers
  input  wire logic [4:0]         fifo_buf,     // current fifo buffer
  output logic                    store_valid,  // store message, pulse
  output logic      [4:0]         store_buf,    // buffer to write
  output logic                    store_fifo,   // target is the fifo
  output logic      [4:0]         filter_hit_code // filter that hit
);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------

  logic [15:0] msel_ff;
  logic [15:0] msid_ff [3];
  logic [15:0] meid_ff [3];
  logic [2:0]  irq_mask_ff;
  logic [2:0]  irq_stat_ff;
  logic [15:0] rdata_ff;

  logic        wr_msel;
  logic [2:0]  wr_msid;
  logic [2:0]  wr_meid;

  // write decode, one hot per register
  assign wr_msel    = reg_wr && (reg_addr == `CRX_OFS_MSEL);
  assign wr_msid[0] = reg_wr && (reg_addr == `CRX_OFS_M0_SID);
  assign wr_msid[1] = reg_wr && (reg_addr == `CRX_OFS_M1_SID);
  assign wr_msid[2] = reg_wr && (reg_addr == `CRX_OFS_M2_SID);
  assign wr_meid[0] = reg_wr && (reg_addr == `CRX_OFS_M0_EID);
  assign wr_meid[1] = reg_wr && (reg_addr == `CRX_OFS_M1_EID);
  assign wr_meid[2] = reg_wr && (reg_addr == `CRX_OFS_M2_EID);

  // selector register; code 11 is stored but selects no mask
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      msel_ff <= `CRX_MSEL_RST;
    end else if (wr_msel) begin
      msel_ff <= reg_wdata;
    end
  end

  // masks get a known zero at reset, safer than leaving them floating
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        msid_ff[i] <= `CRX_MASK_RST;
        meid_ff[i] <= `CRX_MASK_RST;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_msid[i]) begin
          msid_ff[i] <= reg_wdata & `CRX_SID_WMASK;
        end
        if (wr_meid[i]) begin
          meid_ff[i] <= reg_wdata;
        end
      end
    end
  end

  // interrupt mask
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_mask_ff <= 3'h0;
    end else if (reg_wr && (reg_addr == `CRX_OFS_IRQ_MASK)) begin
      irq_mask_ff <= reg_wdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // mask selection and filter comparison
  // ----------------------------------------------------------------

  // unpack the two registers of one mask into its fields
  function automatic crx_mask_type unpack_mask(input logic [15:0] s,
                                               input logic [15:0] e);
    crx_mask_type m;
    m.sid               = s[`CRX_SID_MSB:`CRX_SID_LSB];
    m.eid               = {s[`CRX_EIDH_MSB:0], e};
    m.mask_type_enforce = s[`CRX_MASK_TYPE_ENFORCE_BIT];
    return m;
  endfunction

  // lowest numbered hitting filter wins
  function automatic logic [2:0] first_hit(input logic [NFILT-1:0] h);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = NFILT - 1; i >= 0; i--) begin
      if (h[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  logic [NFILT-1:0] hit;

  for (genvar f = 0; f < NFILT; f++) begin : g_filt
    crx_mask_if   mif ();
    crx_msel_type sel;
    logic [1:0]   idx;

    // two selector bits per filter, filter 8 in the lowest pair
    assign sel = crx_msel_type'(msel_ff[2*f +: 2]);
    // reserved code falls back to index 0 but is marked invalid
    assign idx = (sel == CRX_MSK_RSVD) ? 2'b00 : sel;
    assign mif.valid = (sel != CRX_MSK_RSVD);
    assign mif.mask  = unpack_mask(msid_ff[idx], meid_ff[idx]);

    crx_mask_match u_match (
      .mif                    (mif.dst),
      .msg_sid                (msg_sid),
      .msg_eid                (msg_eid),
      .msg_ide                (msg_ide),
      .filt_en                (filt_en[f]),
      .filt_sid               (filt_sid[11*f +: 11]),
      .filt_eid               (filt_eid[18*f +: 18]),
      .filter_extended_enable (filter_extended_enable[f]),
      .hit                    (hit[f])
    );

    a_type_gate: assert property (@(posedge sys_clk) disable iff (rst)
      (mif.mask.mask_type_enforce
       && (msg_ide != filter_extended_enable[f])) |-> !hit[f])
      else $error("type enforcement let a wrong type hit");
  end

  // ----------------------------------------------------------------
  // acceptance decision and buffer targeting
  // ----------------------------------------------------------------

  logic            hit_any;
  logic [2:0]      win;
  logic [3:0]      win_ptr;
  logic            win_fifo;
  logic [4:0]      win_buf;
  logic            win_full;
  logic            accept;
  logic [NBUF-1:0] rx_buffer_full_flag;
  logic [NBUF-1:0] rx_buffer_overflow_flag;
  logic [NBUF-1:0] full_set;
  logic [NBUF-1:0] ovf_set;
  logic [NBUF-1:0] full_clr;
  logic [NBUF-1:0] ovf_clr;
  logic [NBUF-1:0] win_onehot;

  // decision is combinational so it is ready at the storing edge
  always_comb begin
    hit_any  = |hit;
    win      = first_hit(hit);
    win_ptr  = filter_buffer_pointer[4*win +: 4];
    win_fifo = (win_ptr == `CRX_PTR_FIFO);
    win_buf  = win_fifo ? fifo_buf : {1'b0, win_ptr};
    win_full = rx_buffer_full_flag[win_buf];
  end

  assign accept     = msg_valid && hit_any;
  assign win_onehot = NBUF'(1) << win_buf;

  // a full target keeps its old message and flags overflow instead
  assign full_set = (accept && !win_full) ? win_onehot : '0;
  assign ovf_set  = (accept && win_full) ? win_onehot : '0;

  // writing a zero clears a flag, writing a one leaves it alone
  assign full_clr[15:0]  = (reg_wr && reg_addr == `CRX_OFS_FUL_LO)
                           ? ~reg_wdata : 16'h0000;
  assign full_clr[31:16] = (reg_wr && reg_addr == `CRX_OFS_FUL_HI)
                           ? ~reg_wdata : 16'h0000;
  assign ovf_clr[15:0]   = (reg_wr && reg_addr == `CRX_OFS_OVF_LO)
                           ? ~reg_wdata : 16'h0000;
  assign ovf_clr[31:16]  = (reg_wr && reg_addr == `CRX_OFS_OVF_HI)
                           ? ~reg_wdata : 16'h0000;

  crx_flag_bank #(.NUM(NBUF)) u_full (
    .sys_clk (sys_clk),
    .rst     (rst),
    .set_vec (full_set),
    .clr_vec (full_clr),
    .flags   (rx_buffer_full_flag)
  );

  crx_flag_bank #(.NUM(NBUF)) u_ovf (
    .sys_clk (sys_clk),
    .rst     (rst),
    .set_vec (ovf_set),
    .clr_vec (ovf_clr),
    .flags   (rx_buffer_overflow_flag)
  );

  // ----------------------------------------------------------------
  // store request towards the buffer writer
  // ----------------------------------------------------------------

  logic       store_valid_ff;
  logic [4:0] store_buf_ff;
  logic       store_fifo_ff;
  logic [4:0] hit_code_ff;

  // one cycle after the id: pulse plus target and filter number
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      store_valid_ff <= 1'b0;
      store_buf_ff   <= 5'h00;
      store_fifo_ff  <= 1'b0;
      hit_code_ff    <= 5'h00;
    end else begin
      store_valid_ff <= accept && !win_full;
      if (accept) begin
        store_buf_ff  <= win_buf;
        store_fifo_ff <= win_fifo;
        hit_code_ff   <= 5'(win) + `CRX_FILT_BASE;
      end
    end
  end

  assign store_valid     = store_valid_ff;
  assign store_buf       = store_buf_ff;
  assign store_fifo      = store_fifo_ff;
  assign filter_hit_code = hit_code_ff;

  // ----------------------------------------------------------------
  // interrupt status, cleared by reading it
  // ----------------------------------------------------------------

  logic [2:0] irq_evt;
  logic       stat_rd;

  assign irq_evt[`CRX_IRQ_STORE]  = accept && !win_full;
  assign irq_evt[`CRX_IRQ_OVF]    = accept && win_full;
  assign irq_evt[`CRX_IRQ_REJECT] = msg_valid && !hit_any;
  assign stat_rd = reg_rd && (reg_addr == `CRX_OFS_IRQ_STAT);

  // an event in the read cycle survives the clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_stat_ff <= 3'h0;
    end else begin
      irq_stat_ff <= (stat_rd ? 3'h0 : irq_stat_ff) | irq_evt;
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------

  logic [15:0] rd_mux;

  // unmapped offsets read zero
  always_comb begin
    unique case (reg_addr)
      `CRX_OFS_MSEL:     rd_mux = msel_ff;
      `CRX_OFS_M0_SID:   rd_mux = msid_ff[0] & `CRX_SID_WMASK;
      `CRX_OFS_M0_EID:   rd_mux = meid_ff[0];
      `CRX_OFS_M1_SID:   rd_mux = msid_ff[1] & `CRX_SID_WMASK;
      `CRX_OFS_M1_EID:   rd_mux = meid_ff[1];
      `CRX_OFS_M2_SID:   rd_mux = msid_ff[2] & `CRX_SID_WMASK;
      `CRX_OFS_M2_EID:   rd_mux = meid_ff[2];
      `CRX_OFS_FUL_LO:   rd_mux = rx_buffer_full_flag[15:0];
      `CRX_OFS_FUL_HI:   rd_mux = rx_buffer_full_flag[31:16];
      `CRX_OFS_OVF_LO:   rd_mux = rx_buffer_overflow_flag[15:0];
      `CRX_OFS_OVF_HI:   rd_mux = rx_buffer_overflow_flag[31:16];
      `CRX_OFS_IRQ_STAT: rd_mux = {13'h0000, irq_stat_ff};
      `CRX_OFS_IRQ_MASK: rd_mux = {13'h0000, irq_mask_ff};
      default:           rd_mux = 16'h0000;
    endcase
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  assign reg_rdata = rdata_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------

  a_sel_reset_zero: assert property (@(posedge sys_clk)
    $fell(rst) |-> msel_ff == 16'h0000)
    else $error("selectors not zero after reset");

  a_sid_holes_zero: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_rd && (reg_addr == `CRX_OFS_M1_SID)) |=> reg_rdata[4] == 1'b0
      && reg_rdata[2] == 1'b0)
    else $error("unimplemented mask bits read as one");

  a_store_follows: assert property (@(posedge sys_clk) disable iff (rst)
    (msg_valid && hit_any && !win_full) |=> store_valid
      && store_buf == $past(win_buf))
    else $error("accepted message was not stored one cycle later");

  a_hit_code_num: assert property (@(posedge sys_clk) disable iff (rst)
    store_valid |-> filter_hit_code >= 5'h08 && filter_hit_code <= 5'h0F
      && filter_hit_code == 5'($past(win)) + 5'h08)
    else $error("filter hit code does not name the winner");

  a_fifo_target: assert property (@(posedge sys_clk) disable iff (rst)
    store_valid && store_fifo |-> $past(win_ptr) == 4'hF
      && store_buf == $past(fifo_buf))
    else $error("fifo store without pointer code 1111");

  a_ovf_on_full: assert property (@(posedge sys_clk) disable iff (rst)
    (msg_valid && hit_any && win_full) |=> !store_valid
      && rx_buffer_overflow_flag[$past(win_buf)])
    else $error("overflow not flagged on write to full buffer");

  a_full_set: assert property (@(posedge sys_clk) disable iff (rst)
    store_valid |-> rx_buffer_full_flag[store_buf])
    else $error("stored buffer not marked full");

  a_rsvd_no_hit: assert property (@(posedge sys_clk) disable iff (rst)
    (msel_ff[1:0] == 2'b11) |-> !hit[0])
    else $error("reserved selector produced a hit");

  a_no_hit_no_store: assert property (@(posedge sys_clk) disable iff (rst)
    (msg_valid && !hit_any) ##1 1'b1 |-> !store_valid)
    else $error("store without any filter hit");

endmodule

// [tb_crx_rx_accept.sv]
// self-checking bench for the rx acceptance block
`timescale 1ns/1ps
`include "crx_regs.svh"
module tb_crx_rx_accept;
  import crx_pkg::*;
  logic         sys_clk, rst, reg_wr, reg_rd, irq, msg_valid, msg_ide;
  logic         store_valid, store_fifo;
  logic [4:0]   reg_addr, fifo_buf, store_buf, filter_hit_code;
  logic [15:0]  reg_wdata, reg_rdata;
  logic [10:0]  msg_sid;
  logic [17:0]  msg_eid;
  logic [7:0]   filt_en, filter_extended_enable;
  logic [87:0]  filt_sid;
  logic [143:0] filt_eid;
  logic [31:0]  filter_buffer_pointer;
  int           n_errors, tests_run;

  crx_rx_accept crx_rx_accept_inst (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .msg_valid(msg_valid),
    .msg_sid(msg_sid), .msg_eid(msg_eid), .msg_ide(msg_ide),
    .filt_en(filt_en), .filt_sid(filt_sid), .filt_eid(filt_eid),
    .filter_extended_enable(filter_extended_enable),
    .filter_buffer_pointer(filter_buffer_pointer), .fifo_buf(fifo_buf),
    .store_valid(store_valid), .store_buf(store_buf),
    .store_fifo(store_fifo), .filter_hit_code(filter_hit_code));
  crx_can_node  crx_can_node_inst (.sys_clk(sys_clk), .msg_valid(msg_valid),
    .msg_sid(msg_sid), .msg_eid(msg_eid), .msg_ide(msg_ide));

  // ---------------------------------------------------------------
  // clock, checking and closing
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // register port and message helpers
  // ---------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rchk(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, d);
  endtask

  // every filter points at p; a hit must store one cycle after valid
  task automatic msg(input logic [10:0] s, input logic [17:0] e,
                     input logic x, input logic hit, input logic [3:0] p,
                     input logic [4:0] code);
    @(posedge sys_clk);
    filter_buffer_pointer <= {8{p}};
    crx_can_node_inst.send(s, e, x);
    #1 chk(store_valid, hit);
    if (hit) begin
      chk(store_fifo, p == 4'hF);
      chk(store_buf, (p == 4'hF) ? fifo_buf : {1'b0, p});
      chk(filter_hit_code, code);
    end
  endtask

  task automatic only(input int f);
    @(posedge sys_clk);
    filt_en <= 8'h01 << f;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rchk(`CRX_OFS_MSEL, 16'h0000);
    rchk(`CRX_OFS_FUL_LO, 16'h0000);
    rchk(`CRX_OFS_FUL_HI, 16'h0000);
    rchk(`CRX_OFS_OVF_LO, 16'h0000);
    rchk(`CRX_OFS_OVF_HI, 16'h0000);
    rchk(5'h1F, 16'h0000);
  endtask

  task automatic t_regs;
    wr(`CRX_OFS_MSEL, 16'h9864); // no pair holds the reserved code
    rchk(`CRX_OFS_MSEL, 16'h9864);
    wr(`CRX_OFS_M0_SID, 16'hFFFF);
    rchk(`CRX_OFS_M0_SID, 16'hFFEB);
    wr(`CRX_OFS_M1_SID, 16'hFFFF);
    rchk(`CRX_OFS_M1_SID, 16'hFFEB);
    wr(`CRX_OFS_M0_EID, 16'hA5C3);
    rchk(`CRX_OFS_M0_EID, 16'hA5C3);
  endtask

  // mask0 compares the sid only, mask1 ignores ids but enforces type,
  // mask2 compares every identifier bit
  task automatic t_select;
    wr(`CRX_OFS_M0_SID, 16'hFFE0);
    wr(`CRX_OFS_M0_EID, 16'h0000);
    wr(`CRX_OFS_M1_SID, 16'h0008);
    wr(`CRX_OFS_M1_EID, 16'h0000);
    wr(`CRX_OFS_M2_SID, 16'hFFE3);
    wr(`CRX_OFS_M2_EID, 16'hFFFF);
    only(0);
    wr(`CRX_OFS_MSEL, 16'h0000);
    msg(11'h123, 18'h0_0000, 1'b0, 1'b1, 4'h1, 5'h08);
    msg(11'h122, 18'h0_0000, 1'b0, 1'b0, 4'h1, 5'h08);
    msg(11'h123, 18'h0_0000, 1'b1, 1'b1, 4'h2, 5'h08);
    wr(`CRX_OFS_MSEL, 16'h0001);
    msg(11'h555, 18'h0_0000, 1'b0, 1'b0, 4'h3, 5'h08);
    msg(11'h555, 18'h1_2345, 1'b1, 1'b1, 4'h3, 5'h08);
    wr(`CRX_OFS_MSEL, 16'h0002);
    msg(11'h123, 18'h2_ABCD, 1'b1, 1'b1, 4'h4, 5'h08);
    msg(11'h123, 18'h2_ABCC, 1'b1, 1'b0, 4'h4, 5'h08);
    msg(11'h123, 18'h0_ABCD, 1'b1, 1'b0, 4'h4, 5'h08);
    rchk(`CRX_OFS_FUL_LO, 16'h001E);
  endtask

  // each filter alone, then all at once where the lowest must win;
  // filter 15 gets pointer 1111, so it lands in fifo buffer 0, not 15
  task automatic t_filters;
    wr(`CRX_OFS_MSEL, 16'h0000);
    for (int f = 0; f < 8; f++) begin
      only(f);
      msg(11'h123, 18'h0_0000, 1'b0, 1'b1, 4'(8 + f), 5'(8 + f));
    end
    rchk(`CRX_OFS_FUL_LO, 16'h7F1F);
    @(posedge sys_clk);
    filt_en <= 8'hFF;
    fifo_buf <= 5'h10;
    msg(11'h123, 18'h0_0000, 1'b0, 1'b1, 4'hF, 5'h08);
    rchk(`CRX_OFS_FUL_HI, 16'h0001);
  endtask

  task automatic t_flags;
    wr(`CRX_OFS_FUL_LO, 16'hFFFF);
    rchk(`CRX_OFS_FUL_LO, 16'h7F1F);
    wr(`CRX_OFS_FUL_LO, 16'h00FF);
    rchk(`CRX_OFS_FUL_LO, 16'h001F);
    msg(11'h123, 18'h0_0000, 1'b0, 1'b0, 4'hF, 5'h08);
    rchk(`CRX_OFS_OVF_HI, 16'h0001);
    wr(`CRX_OFS_OVF_HI, 16'hFFFF);
    rchk(`CRX_OFS_OVF_HI, 16'h0001);
    wr(`CRX_OFS_OVF_HI, 16'h0000);
    rchk(`CRX_OFS_OVF_HI, 16'h0000);
    rchk(`CRX_OFS_OVF_LO, 16'h0000);
  endtask

  // stored, overflow and reject events have all happened by now
  task automatic t_irq;
    rchk(`CRX_OFS_IRQ_STAT, 16'h0007);
    wr(`CRX_OFS_IRQ_MASK, 16'h0004);
    #1 chk(irq, 1'b0);
    msg(11'h000, 18'h0_0000, 1'b0, 1'b0, 4'h5, 5'h08);
    chk(irq, 1'b1);
    wr(`CRX_OFS_IRQ_MASK, 16'h0000);
    #1 chk(irq, 1'b0);
    wr(`CRX_OFS_IRQ_MASK, 16'h0007);
    #1 chk(irq, 1'b1);
    rchk(`CRX_OFS_IRQ_STAT, 16'h0004);
    chk(irq, 1'b0);
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    filt_en = 8'h00;
    filter_extended_enable = 8'hFF;
    filt_sid = {8{11'h123}};
    filt_eid = {8{18'h2_ABCD}};
    filter_buffer_pointer = 32'h0000_0000;
    fifo_buf = 5'h00;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_select();
    t_filters();
    t_flags();
    t_irq();
    wrap_up();
  end

  // the whole run needs well under a thousand cycles
  initial begin
    #2_000_000;
    n_errors++;
    wrap_up();
  end
endmodule
